// ### pkg/twbc_pkg.sv
// Constants shared by the two-wire bus controller core and its testbench.
// Assumes a 32-bit APB register bus with byte addresses.
package twbc_pkg;
	localparam logic [7:0] OFF_CTRL1 = 8'h00;
	localparam logic [7:0] OFF_CTRL2 = 8'h04;
	localparam logic [7:0] OFF_DATA = 8'h08;
	localparam logic [7:0] OFF_OWN = 8'h0c;
	localparam logic [7:0] OFF_PRESC = 8'h10;
	localparam logic [7:0] OFF_OPT = 8'h14;
	// control_one fields
	localparam int BCS_LSB = 0;
	localparam int AMD_BIT = 3;
	localparam int HBE_BIT = 4;
	localparam int RATE_LSB = 5;
	// control_two (write) and status_reg (read) fields
	localparam int LRB_BIT = 0;
	localparam int AL_BIT = 3;
	localparam int PIN_BIT = 4;
	localparam int BUSY_BIT = 5;
	localparam int TRX_BIT = 6;
	localparam int MST_BIT = 7;
	// own_address_reg and option_reg fields
	localparam int FFMT_BIT = 0;
	localparam int OWN_LSB = 1;
	localparam int SH_BIT = 0;
	// Reset values
	localparam logic [4:0] PDIV_RST = 5'h01;
	localparam logic PIN_RST = 1'b1;
	// Timing in prescaler periods, and bits per byte
	localparam int START_HOLD_TICKS = 8;
	localparam int HIGH_BASE = 6;
	localparam int LOW_EXTRA = 4;
	localparam int BYTE_BITS = 8;
endpackage

// ### pkg/twbc_psc_if.sv
// Link between the core and its prescaler: divide setting and tick.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ps
interface twbc_psc_if;
	logic [4:0] divide;
	logic tick;
	modport ctl(output divide, input tick);
	modport gen(input divide, output tick);
endinterface

// ### rtl/twbc_prescaler.sv
// Prescaler: one-cycle tick every p system clocks, p from 1 to 32.
// Assumes divide is only changed while the bus is idle.
`timescale 1ns/1ps
module twbc_prescaler (
	input wire logic pclk,
	input wire logic presetn,
	twbc_psc_if.gen psc
);
	typedef struct packed {
		logic [4:0] cnt;
		logic tick;
	} twbc_psc_s;

	twbc_psc_s st;
	twbc_psc_s next_st;
	logic [5:0] limit;

	// A divide field of zero stands for 32
	assign limit = (psc.divide == 5'h00) ? 6'h20 : {1'b0, psc.divide};
	assign psc.tick = st.tick;

	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if ({1'b0, st.cnt} + 6'h01 >= limit) begin
			next_st.cnt = 5'h00;
			next_st.tick = 1'b1;
		end else begin
			next_st.cnt = st.cnt + 5'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule

// ### rtl/twbc_core.sv
// Two-wire bus clock and control core with an APB register slave.
// Assumes open-drain lines resolved outside; inputs synchronous to pclk.
// Notes on behaviour
// - Start hold and stop setup timing
// - Slave releases clock tLOW after service
// - Prescaler divides system clock by 1..32
// - Rate code further divides prescaler clock
// - Bus clock low ends high phase, restarts low count
// - High count waits for bus clock high
// - Master bit written; cleared on stop, loss
// - Addressed slave takes direction into transmit
// - Master sets transmit to inverse of direction bit after address acknowledge
// - Match disable: no match, transmit kept
// - Free format: no address, transmit kept
// - Start request sends preloaded address byte
// - Stop request; bits held until stop
// - Stop waits for released clock line
// - Busy set on start, cleared on stop
// - Master interrupts after programmed clock count
// - Slave interrupts after acknowledging own address
// - Interrupt clears service bit, holds clock low
// - Data access or writing one sets service
// - Address-phase arbitration loss still interrupts
// - One to eight bits plus acknowledge
// - High phase table, low four longer
`timescale 1ns/1ps
module twbc_core (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	output logic transfer_interrupt,
	output logic bus_busy_flag
);
	typedef enum logic [2:0] {
		M_IDLE, M_START, M_LOW, M_HIGHW, M_HIGH, M_STOPH
	} twbc_state_e;

	typedef struct packed {
		logic [2:0] bcs;
		logic hbe;
		logic amd;
		logic [2:0] rate;
		logic [4:0] pdiv;
		logic [6:0] own;
		logic ffmt;
		logic sh;
		logic [7:0] dbuf;
		logic mst;
		logic trx;
		logic pin;
		logic busy;
		logic start_req;
		logic stop_req;
		logic al;
		logic lrb;
		logic addr_ph;
		logic slv_on;
		logic slv_hold;
		logic scl_p;
		logic sda_p;
		logic dlow;
		logic [3:0] bitn;
		twbc_state_e fsm;
		logic [8:0] cnt;
		logic scl_oe;
		logic sda_oe;
		logic irq;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} twbc_reg_s;

	twbc_reg_s st;
	twbc_reg_s next_st;
	twbc_psc_if psc();

	logic tick;
	logic acc;
	logic hit;
	logic [31:0] rdata;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic [3:0] nb;
	logic [3:0] tot;
	logic [8:0] thigh;
	logic [8:0] tlow;
	logic [8:0] tsu;
	logic [8:0] thold;
	logic [7:0] rx_byte;
	logic own_match;

	twbc_prescaler u_psc (
		.pclk(pclk),
		.presetn(presetn),
		.psc(psc)
	);

	assign psc.divide = st.pdiv;
	assign tick = psc.tick;

	// High phase doubles per code on a fixed base; low adds a fixed extra
	assign thigh = (9'h002 << st.rate) + 9'(twbc_pkg::HIGH_BASE);
	assign tlow = thigh + 9'(twbc_pkg::LOW_EXTRA);
	assign tsu = (st.pdiv == 5'h01) ? thigh : thigh - 9'h001;
	assign thold = st.sh ? 9'(twbc_pkg::START_HOLD_TICKS) : thigh;

	assign nb = (st.bcs == 3'h0) ? 4'(twbc_pkg::BYTE_BITS) : {1'b0, st.bcs};
	assign tot = nb + {3'h0, st.hbe};

	assign scl_rise = scl_i & ~st.scl_p;
	assign scl_fall = ~scl_i & st.scl_p;
	assign start_det = st.scl_p & scl_i & st.sda_p & ~sda_i;
	assign stop_det = st.scl_p & scl_i & ~st.sda_p & sda_i;

	assign rx_byte = {st.dbuf[6:0], sda_i};
	// General call is the all-zero byte
	assign own_match = !st.amd && !st.ffmt &&
		(rx_byte[7:1] == st.own || rx_byte == 8'h00);

	assign acc = psel && penable && st.pready;
	assign hit = paddr == twbc_pkg::OFF_CTRL1 ||
		paddr == twbc_pkg::OFF_CTRL2 || paddr == twbc_pkg::OFF_DATA ||
		paddr == twbc_pkg::OFF_OWN || paddr == twbc_pkg::OFF_PRESC ||
		paddr == twbc_pkg::OFF_OPT;

	always_comb begin
		rdata = 32'h0000_0000;
		case (paddr)
			twbc_pkg::OFF_CTRL1: begin
				rdata[twbc_pkg::BCS_LSB +: 3] = st.bcs;
				rdata[twbc_pkg::AMD_BIT] = st.amd;
				rdata[twbc_pkg::HBE_BIT] = st.hbe;
				rdata[twbc_pkg::RATE_LSB +: 3] = st.rate;
			end
			twbc_pkg::OFF_CTRL2: begin
				rdata[twbc_pkg::LRB_BIT] = st.lrb;
				rdata[twbc_pkg::AL_BIT] = st.al;
				rdata[twbc_pkg::PIN_BIT] = st.pin;
				rdata[twbc_pkg::BUSY_BIT] = st.busy;
				rdata[twbc_pkg::TRX_BIT] = st.trx;
				rdata[twbc_pkg::MST_BIT] = st.mst;
			end
			twbc_pkg::OFF_DATA: rdata[7:0] = st.dbuf;
			twbc_pkg::OFF_OWN: begin
				rdata[twbc_pkg::FFMT_BIT] = st.ffmt;
				rdata[twbc_pkg::OWN_LSB +: 7] = st.own;
			end
			twbc_pkg::OFF_PRESC: rdata[4:0] = st.pdiv;
			twbc_pkg::OFF_OPT: rdata[twbc_pkg::SH_BIT] = st.sh;
			default: rdata = 32'h0000_0000;
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.irq = 1'b0;
		next_st.scl_p = scl_i;
		next_st.sda_p = sda_i;
		next_st.pready = 1'b0;
		next_st.pslverr = 1'b0;
		if (psel && !penable) begin
			next_st.pready = 1'b1;
			next_st.pslverr = !hit;
			next_st.prdata = rdata;
		end

		// Software side first, so hardware events below win a tie
		if (acc && pwrite) begin
			case (paddr)
				twbc_pkg::OFF_CTRL1: begin
					next_st.bcs = pwdata[twbc_pkg::BCS_LSB +: 3];
					next_st.amd = pwdata[twbc_pkg::AMD_BIT];
					next_st.hbe = pwdata[twbc_pkg::HBE_BIT];
					next_st.rate = pwdata[twbc_pkg::RATE_LSB +: 3];
				end
				twbc_pkg::OFF_CTRL2: begin
					next_st.mst = pwdata[twbc_pkg::MST_BIT];
					next_st.trx = pwdata[twbc_pkg::TRX_BIT];
					if (pwdata[twbc_pkg::PIN_BIT])
						next_st.pin = 1'b1;
					if (!st.busy && pwdata[twbc_pkg::MST_BIT] &&
							pwdata[twbc_pkg::BUSY_BIT])
						next_st.start_req = 1'b1;
					if (st.busy && pwdata[twbc_pkg::MST_BIT] &&
							!pwdata[twbc_pkg::BUSY_BIT])
						next_st.stop_req = 1'b1;
				end
				twbc_pkg::OFF_DATA: begin
					next_st.dbuf = pwdata[7:0];
					next_st.pin = 1'b1;
					next_st.al = 1'b0;
				end
				twbc_pkg::OFF_OWN: begin
					next_st.ffmt = pwdata[twbc_pkg::FFMT_BIT];
					next_st.own = pwdata[twbc_pkg::OWN_LSB +: 7];
				end
				twbc_pkg::OFF_PRESC: next_st.pdiv = pwdata[4:0];
				twbc_pkg::OFF_OPT: next_st.sh = pwdata[twbc_pkg::SH_BIT];
				default: next_st.pin = next_st.pin;
			endcase
		end
		if (acc && !pwrite && paddr == twbc_pkg::OFF_DATA) begin
			next_st.pin = 1'b1;
			next_st.al = 1'b0;
		end

		// Bit engine shared by master and slave, paced by the bus clock
		if (scl_rise && st.busy && (st.mst || st.slv_on || st.addr_ph) &&
				st.bitn < tot) begin
			next_st.bitn = st.bitn + 4'h1;
			if (st.bitn < nb) begin
				next_st.dbuf = rx_byte;
				// Released line read low while sending: lost the bus
				if (st.mst && st.trx && !st.dlow && !sda_i) begin
					next_st.al = 1'b1;
					next_st.mst = 1'b0;
					next_st.trx = 1'b0;
				end
				if (st.addr_ph && !st.mst && st.bitn == nb - 4'h1 &&
						own_match) begin
					next_st.slv_on = 1'b1;
					next_st.trx = rx_byte[0];
				end
			end else begin
				next_st.lrb = sda_i;
				if (st.addr_ph && st.mst && !sda_i)
					next_st.trx = ~st.dbuf[0];
			end
		end
		if (scl_fall && st.busy && st.bitn == tot &&
				(st.mst || st.slv_on || st.addr_ph)) begin
			next_st.bitn = 4'h0;
			next_st.addr_ph = 1'b0;
			if (st.mst || st.slv_on || (st.al && st.addr_ph)) begin
				next_st.irq = 1'b1;
				next_st.pin = 1'b0;
				next_st.slv_hold = !st.mst;
			end
		end

		// Slave release: tLOW after service, counted in prescaler ticks
		if (st.slv_hold && st.fsm == M_IDLE) begin
			if (!next_st.pin) begin
				next_st.cnt = 9'h000;
			end else if (tick) begin
				if (st.cnt + 9'h001 >= tlow) begin
					next_st.slv_hold = 1'b0;
					next_st.cnt = 9'h000;
				end else begin
					next_st.cnt = st.cnt + 9'h001;
				end
			end
		end

		// Master clock generator
		case (st.fsm)
			M_IDLE: begin
				if (st.start_req && st.mst && !st.slv_hold) begin
					next_st.start_req = 1'b0;
					next_st.fsm = M_START;
					next_st.cnt = 9'h000;
				end
			end
			M_START: begin
				if (tick) begin
					next_st.cnt = st.cnt + 9'h001;
					if (st.cnt + 9'h001 >= thold) begin
						next_st.fsm = M_LOW;
						next_st.cnt = 9'h000;
					end
				end
			end
			M_LOW: begin
				// Clock stays low while service is pending
				if (!st.pin) begin
					next_st.cnt = 9'h000;
				end else if (tick) begin
					next_st.cnt = st.cnt + 9'h001;
					if (st.cnt + 9'h001 >= tlow) begin
						next_st.cnt = 9'h000;
						if (st.stop_req && st.bitn == 4'h0)
							next_st.fsm = M_STOPH;
						else
							next_st.fsm = M_HIGHW;
					end
				end
			end
			M_HIGHW: begin
				if (scl_i) begin
					next_st.fsm = M_HIGH;
					next_st.cnt = 9'h000;
				end
			end
			M_HIGH: begin
				if (!scl_i) begin
					next_st.fsm = M_LOW;
					next_st.cnt = 9'h000;
				end else if (tick) begin
					next_st.cnt = st.cnt + 9'h001;
					if (st.cnt + 9'h001 >= thigh) begin
						next_st.fsm = M_LOW;
						next_st.cnt = 9'h000;
					end
				end
			end
			M_STOPH: begin
				// Another party may stretch the clock; wait for it
				if (!scl_i) begin
					next_st.cnt = 9'h000;
				end else if (tick) begin
					next_st.cnt = st.cnt + 9'h001;
					if (st.cnt + 9'h001 >= tsu) begin
						next_st.fsm = M_IDLE;
						next_st.cnt = 9'h000;
					end
				end
			end
			default: next_st.fsm = M_IDLE;
		endcase
		if (!next_st.mst && st.fsm != M_IDLE && st.fsm != M_STOPH)
			next_st.fsm = M_IDLE;

		// Bus conditions override everything else
		if (start_det) begin
			next_st.busy = 1'b1;
			next_st.bitn = 4'h0;
			next_st.bcs = 3'h0;
			next_st.addr_ph = !st.ffmt;
			next_st.slv_on = st.ffmt && !st.mst;
		end
		if (stop_det) begin
			next_st.busy = 1'b0;
			next_st.mst = 1'b0;
			next_st.stop_req = 1'b0;
			next_st.start_req = 1'b0;
			next_st.slv_on = 1'b0;
			next_st.slv_hold = 1'b0;
			next_st.addr_ph = 1'b0;
			next_st.bitn = 4'h0;
		end

		// Data drive only changes while the clock is low
		if (!scl_i) begin
			next_st.dlow = 1'b0;
			if ((next_st.mst && !next_st.stop_req) || next_st.slv_on ||
					next_st.addr_ph) begin
				if (next_st.bitn < nb)
					next_st.dlow = next_st.trx && !next_st.dbuf[7];
				else if (next_st.bitn == nb && st.hbe)
					next_st.dlow = next_st.addr_ph ?
						(next_st.slv_on && !next_st.mst) :
						(!next_st.trx &&
						(next_st.mst || next_st.slv_on));
			end
		end
		next_st.scl_oe = next_st.fsm == M_LOW || next_st.slv_hold;
		next_st.sda_oe = next_st.dlow || next_st.fsm == M_START ||
			next_st.fsm == M_STOPH ||
			(next_st.fsm == M_LOW && next_st.stop_req &&
			next_st.bitn == 4'h0 && next_st.pin);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.pdiv <= twbc_pkg::PDIV_RST;
			st.pin <= twbc_pkg::PIN_RST;
			st.fsm <= M_IDLE;
			st.scl_p <= 1'b1;
			st.sda_p <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Lines are only ever pulled low; the enable carries the data
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = st.scl_oe;
	assign sda_oe = st.sda_oe;
	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign transfer_interrupt = st.irq;
	assign bus_busy_flag = st.busy;
endmodule

// ### test/twbc_checker.sv
// Port checker for the two-wire bus core, bound to every instance.
// Assumes one pclk domain with presetn active low.
`timescale 1ns/1ps
module twbc_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic transfer_interrupt,
	input wire logic bus_busy_flag
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_after_setup_a: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	err_read_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read returned data");
	lines_low_a: assert property (scl_o == 1'b0 && sda_o == 1'b0)
		else $error("line driven high");
	irq_pulse_a: assert property (transfer_interrupt |=> !transfer_interrupt)
		else $error("interrupt longer than one cycle");
	irq_holds_clock_a: assert property (
		transfer_interrupt |=> scl_oe [*8])
		else $error("clock not held after interrupt");
	busy_on_start_a: assert property (
		$fell(sda_i) && scl_i |-> ##[1:4] bus_busy_flag)
		else $error("busy not set by start");
	busy_off_stop_a: assert property (
		$rose(sda_i) && scl_i |-> ##[1:4] !bus_busy_flag)
		else $error("busy not cleared by stop");
	irq_c: cover property (transfer_interrupt);
	err_c: cover property (pslverr);
	stretch_c: cover property (!scl_i && !scl_oe);
	busy_c: cover property ($rose(bus_busy_flag));
endmodule

bind twbc_core twbc_checker u_chk (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .scl_i, .scl_o,
	.scl_oe, .sda_i, .sda_o, .sda_oe, .transfer_interrupt, .bus_busy_flag);

// ### test/twbc_bus_model.sv
// Far-side receiver: acknowledges the address byte, may stretch lows.
// Assumes the bench resolves both lines as wired-AND with pull-ups.
`timescale 1ns/1ps
module twbc_bus_model (
	input wire logic pclk,
	input wire logic scl,
	input wire logic sda,
	input wire logic [15:0] stretch,
	output logic scl_pull,
	output logic sda_pull,
	output logic [7:0] rx
);
	int nb = 0;
	int cnt = 0;
	logic ps = 1'b1;
	logic pd = 1'b1;
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
		rx = 8'h00;
	end
	always @(posedge pclk) begin
		if (ps && scl && pd && !sda)
			nb = 0;
		if (!ps && scl) begin
			rx <= {rx[6:0], sda};
			nb = nb + 1;
		end
		if (ps && !scl) begin
			// Only the address byte is acknowledged
			sda_pull <= (nb == 8);
			cnt = stretch;
		end else if (cnt != 0)
			cnt = cnt - 1;
		// Stretch starts at the master's fall, so lows only grow
		scl_pull <= (cnt != 0);
		ps <= scl;
		pd <= sda;
	end
endmodule

// ### test/testbench.sv
// Random master transfers through the core to one bus receiver.
// Assumes pull-ups on both lines, resolved here as wired-AND.
`timescale 1ns/1ps
module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, lerr;
	logic transfer_interrupt, bus_busy_flag, scl_pull, sda_pull;
	logic [7:0] rx;
	logic [15:0] stretch = 16'h0;
	logic sclq = 1'b1;
	int n_fail = 0;
	int check_count = 0;
	int hcnt = 0;
	int hi_len = 0;
	int nclk = 0;
	wire scl = ~(scl_oe | scl_pull);
	wire sda = ~(sda_oe | sda_pull);
	always #2 pclk = ~pclk;
	twbc_core u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .scl_i(scl), .scl_o, .scl_oe,
		.sda_i(sda), .sda_o, .sda_oe, .transfer_interrupt, .bus_busy_flag);
	twbc_bus_model u_bus (.pclk, .scl, .sda, .stretch, .scl_pull,
		.sda_pull, .rx);
	always @(posedge pclk) begin
		sclq <= scl;
		if (scl && !sclq)
			nclk <= nclk + 1;
		hcnt <= scl ? hcnt + 1 : 0;
		if (!scl && sclq)
			hi_len <= hcnt;
	end
	function automatic int hi_ticks(int code);
		return (2 << code) + 6;
	endfunction
	task automatic stop_test();
		if (n_fail == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		check_count++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask
	task automatic chkr(string nm, int e, int tol, int g);
		check_count++;
		if (g < e - tol || g > e + tol) begin
			$display("Error %s expected %0d seen %0d", nm, e, g);
			n_fail++;
		end
	endtask
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
		output logic [31:0] r);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16 && pready !== 1'b1; i++)
			@(posedge pclk);
		r = prdata;
		lerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 16) begin
			chkr("pready", 0, 0, i);
			stop_test();
		end
	endtask
	// Waits for an interrupt (k=1) or for the bus to go free (k=0)
	task automatic wait_ev(logic k);
		int i;
		for (i = 0; i < 40000; i++) begin
			@(posedge pclk);
			if (k ? transfer_interrupt === 1'b1 : bus_busy_flag === 1'b0)
				break;
		end
		if (i == 40000) begin
			chkr("event wait", 0, 0, i);
			stop_test();
		end
	endtask
	initial begin
		logic [31:0] r;
		logic [7:0] ab, db, es;
		int p, rate, th, tl, n, c, n0, hs;
		r = $urandom(32'h63eb8275);
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, twbc_pkg::OFF_CTRL2, 0, r);
		chk("status", 8'h10, r[7:0]);
		apb(0, twbc_pkg::OFF_PRESC, 0, r);
		chk("prescaler", 8'h01, r[7:0]);
		apb(0, 8'h18, 0, r);
		chk("unmapped", 8'h01, {7'h0, lerr});
		for (int k = 0; k < 3; k++) begin
			p = 13 + $urandom % 20;
			rate = $urandom % 3;
			hs = $urandom % 2;
			n = 1 + $urandom % 7;
			th = hi_ticks(rate) * p;
			tl = th + 4 * p;
			// Direction bit is random so both turnarounds of transmit occur
			ab = 8'($urandom);
			db = 8'($urandom);
			stretch <= (k == 1) ? 16'(tl + 40) : 16'h0;
			apb(1, twbc_pkg::OFF_PRESC, 32'(p), r);
			apb(1, twbc_pkg::OFF_OPT, 32'(hs), r);
			apb(1, twbc_pkg::OFF_CTRL1, 32'({3'(rate), 5'h10 | 5'(n)}), r);
			apb(1, twbc_pkg::OFF_DATA, 32'(ab), r);
			apb(1, twbc_pkg::OFF_CTRL2, 32'hf0, r);
			c = 0;
			for (int i = 0; i < 9000 && scl_oe !== 1'b1; i++) begin
				@(posedge pclk);
				c += sda_oe === 1'b1;
			end
			if (scl_oe !== 1'b1) begin
				chkr("start wait", 0, 0, 1);
				stop_test();
			end
			chkr("start hold", hs ? 8 * p : th, p + 2, c);
			n0 = nclk;
			wait_ev(1);
			chkr("clocks", 9, 0, nclk - n0);
			chkr("high", th, p + 3, hi_len);
			chk("rx address", {ab[6:0], 1'b0}, rx);
			apb(0, twbc_pkg::OFF_CTRL1, 0, r);
			chk("bit count", {3'(rate), 5'h10}, r[7:0]);
			// Read before any write so hardware's transmit value is seen
			es = ab[0] ? 8'ha0 : 8'he0;
			apb(0, twbc_pkg::OFF_CTRL2, 0, r);
			chk("status", es, r[7:0]);
			apb(1, twbc_pkg::OFF_CTRL2, 32'(es), r);
			apb(0, twbc_pkg::OFF_CTRL2, 0, r);
			chk("status", es, r[7:0]);
			chk("clock held", 8'h01, {7'h0, scl_oe});
			apb(1, twbc_pkg::OFF_CTRL1, 32'({3'(rate), 5'h10 | 5'(n)}), r);
			apb(1, twbc_pkg::OFF_DATA, 32'(db), r);
			c = 0;
			for (int i = 0; i < 9000 && scl_oe === 1'b1; i++) begin
				@(posedge pclk);
				c++;
			end
			if (scl_oe === 1'b1) begin
				chkr("release wait", 0, 0, 1);
				stop_test();
			end
			chkr("release", tl, p + 3, c);
			n0 = nclk;
			wait_ev(1);
			chkr("clocks", n + 1, 0, nclk - n0);
			// As receiver the master leaves data high and acknowledges low
			chk("rx data", ab[0] ? 8'((1 << (n + 1)) - 2) :
				8'({db >> (8 - n), 1'b1}),
				rx & 8'((1 << (n + 1)) - 1));
			apb(1, twbc_pkg::OFF_CTRL2, 32'hd0, r);
			wait_ev(0);
			apb(0, twbc_pkg::OFF_CTRL2, 0, r);
			chk("status", 8'h10, r[7:0] & 8'hb0);
		end
		stop_test();
	end
endmodule
